/* logic/jcp_top.v */
// Test-port configuration loader: TAP controller, instruction decode,
// bypass/identification/sample paths and configuration sequencing.
// Assumes test pins and config pins arrive asynchronous to MCLK.
//
// How it works
// - Mode select sampled and controller steps on each rising test-clock edge unless a full buffer stalls program shifting
// - Shift and capture on rising edge, output drive on falling edge
// - Mode select high keeps controller in reset; clock low does nothing
// - Bypass routes serial data through one flop, nothing else changes
// - Bypassed data appears at the data output one test-clock later
// - Configuration-complete flag readable through the check instruction
// - Extra test-clock cycles after the last bit finish initialization
// - Test pins always act as test pins in every configuration state
// - Bypass, identification and sample never disturb running configuration
// - I/O setup gives port the buffers; after detach it stops config
// - I/O setup leaves the configuration status line untouched
// - Detach puts active configuration controller into idle
// - Reattach re-engages a detached active configuration controller
// - Global clear and output enable ignored by test-port operations
// - Chain-enable output free for user use when not chained
// - Instructions and data shifted in on the rising test-clock edge
// - Data output changes on falling edge, released when not shifting
// - Test-port load aborts any other configuration at once
// - User I/O released while test-port configuration runs
`timescale 1ns/1ps
`include "jcp_defines.vh"
module jcp_top #(
  parameter WORD_W = `JCP_CFG_WORD_W,
  parameter DEPTH = `JCP_FIFO_DEPTH
) (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // Test port
  input wire TCK,
  input wire TMS,
  input wire TDI,
  output reg TDO,
  output reg TDO_OE_N,
  // Configuration pins
  input wire CHAIN_ENABLE_INPUT_N,
  input wire CONFIG_REQUEST_LINE_N,
  input wire GLOBAL_CLEAR_INPUT_N,
  input wire GLOBAL_OUTPUT_ENABLE_INPUT,
  input wire ACTIVE_CFG_BUSY,
  output reg CONFIG_COMPLETE_FLAG,
  output reg CONFIG_STATUS_LINE_N,
  output reg ACTIVE_CFG_IDLE,
  output reg USER_IO_HIZ,
  output reg IO_BY_PORT,
  output reg USER_MODE,
  // Configuration memory write
  output reg CFG_WR,
  output reg [WORD_W-1:0] CFG_DATA,
  input wire CFG_READY
);
  // --------------------------------------------------------------------
  // Pin synchronisers and test-clock edge finder
  // --------------------------------------------------------------------
  reg [3:0] s1_r;
  reg [3:0] s2_r;
  reg tck_d_r;
  wire tck_s = s2_r[0];
  wire tms_s = s2_r[1];
  wire tdi_s = s2_r[2];
  wire busy_s = s2_r[3];
  wire rise = tck_s & ~tck_d_r;
  wire fall = ~tck_s & tck_d_r;

  // Global clear and output enable deliberately feed nothing here.
  // No chain-enable output is driven; that pin stays free for user.
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      tck_d_r <= 1'b0;
    end else begin
      s1_r <= {ACTIVE_CFG_BUSY, TDI, TMS, TCK};
      s2_r <= s1_r;
      tck_d_r <= tck_s;
    end
  end

  // --------------------------------------------------------------------
  // Controller
  // --------------------------------------------------------------------
  reg [3:0] st_r;
  reg [3:0] st_nxt;
  always @* begin
    case (st_r)
      `JCP_ST_RESET: st_nxt = tms_s ? `JCP_ST_RESET : `JCP_ST_IDLE;
      `JCP_ST_IDLE: st_nxt = tms_s ? `JCP_ST_SEL_DR : `JCP_ST_IDLE;
      `JCP_ST_SEL_DR: st_nxt = tms_s ? `JCP_ST_SEL_IR : `JCP_ST_CAP_DR;
      `JCP_ST_CAP_DR: st_nxt = tms_s ? `JCP_ST_EX1_DR : `JCP_ST_SH_DR;
      `JCP_ST_SH_DR: st_nxt = tms_s ? `JCP_ST_EX1_DR : `JCP_ST_SH_DR;
      `JCP_ST_EX1_DR: st_nxt = tms_s ? `JCP_ST_UP_DR : `JCP_ST_PA_DR;
      `JCP_ST_PA_DR: st_nxt = tms_s ? `JCP_ST_EX2_DR : `JCP_ST_PA_DR;
      `JCP_ST_EX2_DR: st_nxt = tms_s ? `JCP_ST_UP_DR : `JCP_ST_SH_DR;
      `JCP_ST_UP_DR: st_nxt = tms_s ? `JCP_ST_SEL_DR : `JCP_ST_IDLE;
      `JCP_ST_SEL_IR: st_nxt = tms_s ? `JCP_ST_RESET : `JCP_ST_CAP_IR;
      `JCP_ST_CAP_IR: st_nxt = tms_s ? `JCP_ST_EX1_IR : `JCP_ST_SH_IR;
      `JCP_ST_SH_IR: st_nxt = tms_s ? `JCP_ST_EX1_IR : `JCP_ST_SH_IR;
      `JCP_ST_EX1_IR: st_nxt = tms_s ? `JCP_ST_UP_IR : `JCP_ST_PA_IR;
      `JCP_ST_PA_IR: st_nxt = tms_s ? `JCP_ST_EX2_IR : `JCP_ST_PA_IR;
      `JCP_ST_EX2_IR: st_nxt = tms_s ? `JCP_ST_UP_IR : `JCP_ST_SH_IR;
      `JCP_ST_UP_IR: st_nxt = tms_s ? `JCP_ST_SEL_DR : `JCP_ST_IDLE;
      default: st_nxt = `JCP_ST_RESET;
    endcase
  end

  // --------------------------------------------------------------------
  // Instruction and data registers
  // --------------------------------------------------------------------
  reg [`JCP_IR_W-1:0] ir_sh_r;
  reg [`JCP_IR_W-1:0] ir_r;
  reg byp_r;
  reg [31:0] dr_r;
  reg [2:0] bit_r;
  reg [WORD_W-1:0] word_r;
  reg word_v_r;
  reg detached_r;
  reg loading_r;
  reg init_r;
  reg [11:0] init_cnt_r;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WORD_W-1:0] fifo_out_data;

  wire op_prog = (ir_r == `JCP_OP_PROGRAM);
  wire op_id = (ir_r == `JCP_OP_IDCODE);
  wire op_smp = (ir_r == `JCP_OP_SAMPLE);
  wire op_chk = (ir_r == `JCP_OP_CHECK);
  wire sel_ir = (st_r >= `JCP_ST_SEL_IR);
  wire prog_sh = (st_r == `JCP_ST_SH_DR) & op_prog;
  // Shifting stalls while the buffer is full so no bit is lost
  wire step = rise & ~(prog_sh & word_v_r & ~fifo_in_ready);

  // Mode select high returns controller to reset within five unstalled rising edges.
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= `JCP_ST_RESET;
    end else if (step) begin
      st_r <= st_nxt;
    end
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ir_sh_r <= {`JCP_IR_W{1'b0}};
      ir_r <= `JCP_OP_IDCODE;
      byp_r <= 1'b0;
      dr_r <= 32'h0;
      bit_r <= 3'h0;
      word_r <= {WORD_W{1'b0}};
      word_v_r <= 1'b0;
      detached_r <= 1'b0;
      loading_r <= 1'b0;
      init_r <= 1'b0;
      init_cnt_r <= 12'h0;
    end else begin
      if (word_v_r && fifo_in_ready) begin
        word_v_r <= 1'b0;
      end
      if (step) begin
        case (st_r)
          `JCP_ST_RESET: begin
            ir_r <= `JCP_OP_IDCODE;
          end
          `JCP_ST_CAP_IR: begin
            ir_sh_r <= {{(`JCP_IR_W-2){1'b0}}, 2'b01};
          end
          `JCP_ST_SH_IR: begin
            ir_sh_r <= {tdi_s, ir_sh_r[`JCP_IR_W-1:1]};
          end
          `JCP_ST_UP_IR: begin
            ir_r <= ir_sh_r;
            if (ir_sh_r == `JCP_OP_DISENGAGE) begin
              detached_r <= 1'b1;
            end
            if (ir_sh_r == `JCP_OP_ENGAGE) begin
              detached_r <= 1'b0;
            end
            if (ir_sh_r == `JCP_OP_PROGRAM) begin
              loading_r <= 1'b1;
              bit_r <= 3'h0;
              init_r <= 1'b0;
              init_cnt_r <= 12'h0;
            end
            if (ir_sh_r == `JCP_OP_IO_SETUP && detached_r) begin
              loading_r <= 1'b0;
            end
          end
          `JCP_ST_CAP_DR: begin
            byp_r <= 1'b0;
            if (op_id) begin
              dr_r <= `JCP_IDCODE_VAL;
            end else if (op_smp) begin
              dr_r <= {29'h0, busy_s, CONFIG_STATUS_LINE_N, tdi_s};
            end else if (op_chk) begin
              dr_r <= {31'h0, CONFIG_COMPLETE_FLAG};
            end
          end
          `JCP_ST_SH_DR: begin
            byp_r <= tdi_s;
            dr_r <= {tdi_s, dr_r[31:1]};
            if (op_prog) begin
              word_r <= {tdi_s, word_r[WORD_W-1:1]};
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) begin
                word_v_r <= 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
        // Startup runs on extra test clocks after the last bit.
        if (ir_r == `JCP_OP_STARTUP && st_r == `JCP_ST_IDLE &&
            loading_r) begin
          init_r <= 1'b1;
          if (init_cnt_r == `JCP_INIT_CYCLES - 12'd1) begin
            loading_r <= 1'b0;
          end else begin
            init_cnt_r <= init_cnt_r + 12'd1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Configuration word buffer
  // --------------------------------------------------------------------
  jcp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH),
    .AW(4)
  ) jcp_fifo_i (
    .clk(MCLK),
    .rst_n(RST_N),
    .flush(1'b0),
    .in_valid(word_v_r),
    .in_ready(fifo_in_ready),
    .in_data(word_r),
    .out_valid(fifo_out_valid),
    .out_ready(CFG_READY & ~CFG_WR),
    .out_data(fifo_out_data)
  );

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  wire tdo_src = sel_ir ? ir_sh_r[0] :
                 (op_id | op_smp | op_chk | op_prog) ? dr_r[0] : byp_r;
  wire shifting = (st_r == `JCP_ST_SH_DR) | (st_r == `JCP_ST_SH_IR);

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      TDO <= 1'b0;
      TDO_OE_N <= 1'b1;
      CONFIG_COMPLETE_FLAG <= 1'b0;
      CONFIG_STATUS_LINE_N <= 1'b1;
      ACTIVE_CFG_IDLE <= 1'b0;
      USER_IO_HIZ <= 1'b1;
      IO_BY_PORT <= 1'b0;
      USER_MODE <= 1'b0;
      CFG_WR <= 1'b0;
      CFG_DATA <= {WORD_W{1'b0}};
    end else begin
      if (fall) begin
        TDO <= tdo_src;
        TDO_OE_N <= ~shifting;
      end
      // Test port never waits on chain-enable or config-request.
      ACTIVE_CFG_IDLE <= detached_r | loading_r;
      IO_BY_PORT <= (ir_r == `JCP_OP_IO_SETUP);
      // Status line left alone by I/O setup.
      CONFIG_STATUS_LINE_N <= 1'b1;
      USER_IO_HIZ <= loading_r | ~USER_MODE;
      if (st_r == `JCP_ST_UP_IR && ir_sh_r == `JCP_OP_PROGRAM && step) begin
        CONFIG_COMPLETE_FLAG <= 1'b0;
        USER_MODE <= 1'b0;
        USER_IO_HIZ <= 1'b1;
      end else if (ir_r == `JCP_OP_IO_SETUP && detached_r) begin
        USER_MODE <= 1'b0;
        USER_IO_HIZ <= 1'b1;
      end else if (init_r && !loading_r) begin
        CONFIG_COMPLETE_FLAG <= 1'b1;
        USER_MODE <= 1'b1;
      end
      // Bypass, sample and identification reach no config state.
      CFG_WR <= fifo_out_valid & CFG_READY & ~CFG_WR;
      if (fifo_out_valid & CFG_READY & ~CFG_WR) begin
        CFG_DATA <= fifo_out_data;
      end
    end
  end
endmodule

/* logic/jcp_defines.vh */
// Constants for the test-port configuration loader.
// Assumes inclusion by bare name; definitions only.
`ifndef JCP_DEFINES_VH
`define JCP_DEFINES_VH
// ----------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------
`define JCP_IR_W 10
`define JCP_OP_EXTEST 10'h000
`define JCP_OP_SAMPLE 10'h005
`define JCP_OP_IDCODE 10'h006
`define JCP_OP_PROGRAM 10'h002
`define JCP_OP_STARTUP 10'h003
`define JCP_OP_CHECK 10'h004
`define JCP_OP_DISENGAGE 10'h2d0
`define JCP_OP_ENGAGE 10'h2b0
`define JCP_OP_IO_SETUP 10'h00d
`define JCP_OP_BYPASS 10'h3ff
// Arbitrary identification value, names no maker or part
`define JCP_IDCODE_VAL 32'h0a5a5001
// ----------------------------------------------------------------------
// Test-port controller states
// ----------------------------------------------------------------------
`define JCP_ST_RESET 4'h0
`define JCP_ST_IDLE 4'h1
`define JCP_ST_SEL_DR 4'h2
`define JCP_ST_CAP_DR 4'h3
`define JCP_ST_SH_DR 4'h4
`define JCP_ST_EX1_DR 4'h5
`define JCP_ST_PA_DR 4'h6
`define JCP_ST_EX2_DR 4'h7
`define JCP_ST_UP_DR 4'h8
`define JCP_ST_SEL_IR 4'h9
`define JCP_ST_CAP_IR 4'ha
`define JCP_ST_SH_IR 4'hb
`define JCP_ST_EX1_IR 4'hc
`define JCP_ST_PA_IR 4'hd
`define JCP_ST_EX2_IR 4'he
`define JCP_ST_UP_IR 4'hf
// ----------------------------------------------------------------------
// Configuration sequencing
// ----------------------------------------------------------------------
`define JCP_INIT_CYCLES 12'd3180
`define JCP_CFG_WORD_W 8
`define JCP_FIFO_DEPTH 16
`endif

/* logic/jcp_fifo.v */
// Word FIFO between the serial loader and the configuration memory.
// Assumes one clock; valid/ready handshake on both sides.
`timescale 1ns/1ps
module jcp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire flush,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

/* verification/jcp_top_sva.sv */
// Port checker for the test-port configuration loader.
// Assumes one clock domain, MCLK, with active-low asynchronous reset.
`timescale 1ns/1ps
module jcp_top_sva #(
  parameter WORD_W = 8
) (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // Test port
  input wire TCK,
  input wire TDO,
  // Configuration state
  input wire CONFIG_COMPLETE_FLAG,
  input wire CONFIG_STATUS_LINE_N,
  input wire USER_IO_HIZ,
  input wire IO_BY_PORT,
  input wire USER_MODE,
  // Configuration memory write
  input wire CFG_WR,
  input wire [WORD_W-1:0] CFG_DATA,
  input wire CFG_READY
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  status_hold_a: assert property (
    IO_BY_PORT |-> CONFIG_STATUS_LINE_N) else $error("status pulled low");
  tdo_fall_a: assert property (
    $changed(TDO) |-> !$past(TCK, 2)) else $error("output off falling edge");
  hiz_user_a: assert property (
    !USER_MODE |-> USER_IO_HIZ) else $error("user pins driven early");
  mode_flag_a: assert property (
    USER_MODE |-> CONFIG_COMPLETE_FLAG) else $error("user mode without flag");
  flag_mode_a: assert property (
    $rose(CONFIG_COMPLETE_FLAG) |-> ##[0:2] USER_MODE)
    else $error("user mode late");
  write_hiz_a: assert property (
    CFG_WR |-> USER_IO_HIZ) else $error("write with user pins driven");
  write_pulse_a: assert property (
    CFG_WR |=> !CFG_WR) else $error("write pulse too long");
  data_hold_a: assert property (
    $changed(CFG_DATA) |-> CFG_WR) else $error("data moved without write");
  write_cause_a: assert property (
    CFG_WR |-> $past(CFG_READY)) else $error("write without ready");
endmodule

/* verification/jcp_prog.sv */
// Programmer model: drives test clock, mode select and data input.
// Assumes the bench calls its tasks; the clock stands still between them.
`timescale 1ns/1ps
module jcp_prog (
  // Test port
  output reg tck,
  output reg tms,
  output reg tdi,
  input wire tdo
);
  integer gap = 0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One test-clock period; returns the output seen before the fall
  task bit_clk(input logic m, input logic d, output logic q);
    begin
      tms = m;
      tdi = d;
      #40;
      tck = 1'b1;
      #79;
      q = tdo;
      #1;
      tck = 1'b0;
      #(40 + gap);
    end
  endtask
  task shift(input logic [31:0] d, input int n, output logic [31:0] q);
    logic x;
    int i;
    begin
      q = 32'h0;
      for (i = 0; i < n; i++) begin
        bit_clk(i == n - 1, d[i], x);
        q[i] = x;
      end
      bit_clk(1'b1, 1'b1, x);
      bit_clk(1'b0, 1'b1, x);
    end
  endtask
  task go_ir(input logic [9:0] op, output logic [31:0] q);
    logic x;
    begin
      bit_clk(1'b1, 1'b1, x);
      bit_clk(1'b1, 1'b1, x);
      bit_clk(1'b0, 1'b1, x);
      bit_clk(1'b0, 1'b1, x);
      shift({22'h0, op}, 10, q);
    end
  endtask
  task go_dr(input logic [31:0] d, input int n, output logic [31:0] q);
    logic x;
    begin
      bit_clk(1'b1, 1'b1, x);
      bit_clk(1'b0, 1'b1, x);
      bit_clk(1'b0, 1'b1, x);
      shift(d, n, q);
    end
  endtask
endmodule

/* verification/jtag_configuration_port_bench.sv */
// Self-checking bench for the test-port configuration loader.
// Assumes jcp_top, jcp_prog and jcp_top_sva are compiled first.
`timescale 1ns/1ps
`include "jcp_defines.vh"
module jtag_configuration_port_bench;
  logic mclk = 0, rst_n = 0, cfg_ready = 0, clr_n = 1, oe = 0, busy = 0;
  logic tck, tms, tdi, tdo, tdo_oe_n, flag, status_n, act_idle;
  logic io_hiz, io_port, user_mode, cfg_wr, x;
  logic [7:0] cfg_data;
  logic [31:0] q, d, r;
  logic [7:0] exp_q[$];
  wire tdo_pin;
  integer seed = 24712;
  integer n_fail = 0;
  integer cmp_count = 0;
  int i, j;
  // Released output shows the inverse of its last value
  assign tdo_pin = tdo_oe_n ? ~tdo : tdo;
  jcp_top jcp_top_i (.MCLK(mclk), .RST_N(rst_n), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
    .CHAIN_ENABLE_INPUT_N(1'b0),
    .CONFIG_REQUEST_LINE_N(1'b1),
    .GLOBAL_CLEAR_INPUT_N(clr_n), .GLOBAL_OUTPUT_ENABLE_INPUT(oe),
    .ACTIVE_CFG_BUSY(busy), .CONFIG_COMPLETE_FLAG(flag),
    .CONFIG_STATUS_LINE_N(status_n), .ACTIVE_CFG_IDLE(act_idle),
    .USER_IO_HIZ(io_hiz), .IO_BY_PORT(io_port), .USER_MODE(user_mode),
    .CFG_WR(cfg_wr), .CFG_DATA(cfg_data), .CFG_READY(cfg_ready));
  jcp_prog jcp_prog_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
  // ----------------------------------------------------------------
  // Clock, random pins, write monitor
  // ----------------------------------------------------------------
  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    #1;
    r = $random(seed);
    cfg_ready = r[1:0] != 2'b00;
    clr_n = r[2];
    oe = r[3];
    busy = r[4];
  end
  always @(negedge mclk) begin
    if (cfg_wr === 1'b1) begin
      chk(cfg_data, exp_q.size() ? exp_q[0] : 8'hxx);
      if (exp_q.size()) exp_q.pop_front();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count++;
      if (seen !== exp) begin
        n_fail++;
        $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    n_fail++;
    end_of_test;
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_n = 1;
    #100;
    chk({tdo_oe_n, flag, status_n, io_hiz, user_mode, cfg_wr}, 6'h2c);
    jcp_prog_i.bit_clk(1'b0, 1'b1, x);
    d = $random(seed);
    jcp_prog_i.go_dr(d, 32, q);
    chk(q, `JCP_IDCODE_VAL);
    for (i = 0; i < 2; i++) begin
      jcp_prog_i.go_ir(i ? 10'h1c7 : `JCP_OP_BYPASS, q);
      chk(q[1:0], 2'b01);
      d = $random(seed);
      jcp_prog_i.go_dr(d, 20, q);
      chk(q[19:0], {d[18:0], 1'b0});
      chk(tdo_oe_n, 1'b1);
    end
    jcp_prog_i.go_ir(`JCP_OP_PROGRAM, q);
    chk({flag, io_hiz, act_idle}, 3'b011);
    jcp_prog_i.gap = 400;
    for (i = 0; i < 3; i++) begin
      d = $random(seed);
      for (j = 0; j < 4; j++) exp_q.push_back(d[8*j +: 8]);
      jcp_prog_i.go_dr(d, 32, q);
    end
    jcp_prog_i.gap = 0;
    for (i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge mclk);
    chk(exp_q.size(), 0);
    jcp_prog_i.go_ir(`JCP_OP_IDCODE, q);
    jcp_prog_i.go_dr(d, 32, q);
    chk(q, `JCP_IDCODE_VAL);
    chk(flag, 1'b0);
    jcp_prog_i.go_ir(`JCP_OP_STARTUP, q);
    for (i = 0; i < `JCP_INIT_CYCLES - 1; i++)
      jcp_prog_i.bit_clk(1'b0, 1'b1, x);
    chk(flag, 1'b0);
    jcp_prog_i.bit_clk(1'b0, 1'b1, x);
    #100;
    chk({flag, user_mode, io_hiz}, 3'b110);
    jcp_prog_i.go_ir(`JCP_OP_CHECK, q);
    jcp_prog_i.go_dr(32'h0, 1, q);
    chk(q[0], 1'b1);
    jcp_prog_i.go_ir(`JCP_OP_DISENGAGE, q);
    chk(act_idle, 1'b1);
    jcp_prog_i.go_ir(`JCP_OP_IO_SETUP, q);
    chk({io_port, status_n, user_mode}, 3'b110);
    jcp_prog_i.go_ir(`JCP_OP_ENGAGE, q);
    chk({act_idle, io_port, user_mode}, 3'b001);
    for (i = 0; i < 5; i++) jcp_prog_i.bit_clk(1'b1, 1'b1, x);
    jcp_prog_i.bit_clk(1'b0, 1'b1, x);
    jcp_prog_i.go_dr(d, 32, q);
    chk(q, `JCP_IDCODE_VAL);
    end_of_test;
  end
endmodule
bind jcp_top jcp_top_sva #(.WORD_W(WORD_W)) jcp_top_sva_i (.MCLK(MCLK),
  .RST_N(RST_N), .TCK(TCK), .TDO(TDO),
  .CONFIG_COMPLETE_FLAG(CONFIG_COMPLETE_FLAG),
  .CONFIG_STATUS_LINE_N(CONFIG_STATUS_LINE_N), .USER_IO_HIZ(USER_IO_HIZ),
  .IO_BY_PORT(IO_BY_PORT), .USER_MODE(USER_MODE), .CFG_WR(CFG_WR),
  .CFG_DATA(CFG_DATA), .CFG_READY(CFG_READY));
